// ### hmi_pkg.sv
// Constants and types of the host access port
package hmi_pkg;
  localparam int          SOCKETS         = 4;
  localparam int          CLOCK_NS        = 100;
  localparam int          RESET_MIN_NS    = 2000;
  localparam int          RESET_MIN_CYC   = (RESET_MIN_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam logic [14:0] COMMON_END      = 15'h0030;
  localparam logic [14:0] SOCK_BASE       = 15'h0400;
  localparam logic [14:0] SOCK_END        = 15'h0800;
  localparam logic [14:0] TX_BASE         = 15'h4000;
  localparam logic [14:0] RX_BASE         = 15'h6000;
  localparam int          REG_DEPTH       = 2048;
  localparam int          BUF_DEPTH       = 16384;
  localparam logic [14:0] GIRQ_FLAG_OFS   = 15'h0015;
  localparam logic [14:0] GIRQ_MASK_OFS   = 15'h0016;
  localparam logic [7:0]  SIRQ_FLAG_OFS   = 8'h02;
  localparam logic [7:0]  SIRQ_MASK_OFS   = 8'h2c;
  localparam logic [7:0]  SPI_WRITE_OP    = 8'hf0;
  localparam logic [7:0]  SPI_READ_OP     = 8'h0f;
  localparam logic [4:0]  SPI_HDR_LAST    = 5'h18;
  localparam logic [4:0]  SPI_FRAME_LAST  = 5'h1f;
  localparam logic [3:0]  SOCK_MASK_RESET = 4'hf;
  localparam logic [3:0]  GLOB_MASK_RESET = 4'hf;

  // Four event bits per socket, as seen in its flag register
  typedef struct packed {
    logic timeout;
    logic receive;
    logic disconnect;
    logic connect;
  } hmi_sock_ev_t;

  // All pins from outside the clock domain
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0]  data;
    logic        csN;
    logic        wrN;
    logic        rdN;
    logic        strap;
    logic        sclk;
    logic        ssN;
    logic        mosi;
  } hmi_pins_t;

  localparam int PIN_W = $bits(hmi_pins_t);
endpackage

// ### hmi_host_port.sv
// Host access port: parallel bus, serial slave, buffer memory and socket interrupts
`timescale 1ns/100ps
module hmi_host_port
(
  input  wire logic                              clock,
  input  wire logic                              reset_n,
  input  wire logic [14:0]                       hostAddressBus,
  input  wire logic [7:0]                        hostDataIn,
  output      logic [7:0]                        hostDataOut,
  output      logic                              hostDataOe,
  input  wire logic                              chipSelect_n,
  input  wire logic                              writeStrobe_n,
  input  wire logic                              readStrobe_n,
  output      logic                              irq_n,
  input  wire logic                              serialModeStrap,
  input  wire logic                              serialClock,
  input  wire logic                              serialSelect_n,
  input  wire logic                              serialDataIn,
  output      logic                              serialDataOut,
  output      logic                              serialDataOe,
  input  wire hmi_pkg::hmi_sock_ev_t [3:0]       socketEvent
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin filter: three stages, change taken once stages two and three agree
  logic [hmi_pkg::PIN_W-1:0] pinRaw;
  logic [hmi_pkg::PIN_W-1:0] pinS1;
  logic [hmi_pkg::PIN_W-1:0] pinS2;
  logic [hmi_pkg::PIN_W-1:0] pinS3;
  logic [hmi_pkg::PIN_W-1:0] pinFilt;
  logic [hmi_pkg::PIN_W-1:0] next_pinFilt;
  hmi_pkg::hmi_pins_t        pinF;

  assign pinRaw = {hostAddressBus, hostDataIn, chipSelect_n, writeStrobe_n, readStrobe_n,
                   serialModeStrap, serialClock, serialSelect_n, serialDataIn};
  assign pinF   = hmi_pkg::hmi_pins_t'(pinFilt);

  genvar gi;
  generate
    for (gi = 0; gi < hmi_pkg::PIN_W; gi++)
    begin : g_pin
      always_comb
      begin
        next_pinFilt[gi] = (pinS2[gi] == pinS3[gi]) ? pinS3[gi] : pinFilt[gi];
      end
    end
  endgenerate

  // Strobes and selects idle high so nothing fires out of reset
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinS1   <= '1;
      pinS2   <= '1;
      pinS3   <= '1;
      pinFilt <= '1;
    end
    else
    begin
      pinS1   <= pinRaw;
      pinS2   <= pinS1;
      pinS3   <= pinS2;
      pinFilt <= next_pinFilt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access selection and serial frame logic
  logic        wrPrev;
  logic        sclkPrev;
  logic [4:0]  bitCount;
  logic [4:0]  next_bitCount;
  logic [31:0] shiftIn;
  logic [31:0] next_shiftIn;
  logic [7:0]  misoShift;
  logic [7:0]  next_misoShift;
  logic [31:0] frame;
  logic        parSel;
  logic        parWrite;
  logic        spiSel;
  logic        sclkRise;
  logic        sclkFall;
  logic        spiWrite;
  logic        accWrite;
  logic [14:0] accAddr;
  logic [7:0]  accData;
  logic [7:0]  readByte;

  always_comb
  begin
    // chip select and strap pick the path
    parSel   = !pinF.csN && !pinF.strap;
    spiSel   = pinF.strap && !pinF.ssN;
    // strobes count only under chip select
    parWrite = parSel && !wrPrev && pinF.wrN;
    // sample on rise, shift on fall suits modes 0 and 3
    sclkRise = spiSel && pinF.sclk && !sclkPrev;
    sclkFall = spiSel && !pinF.sclk && sclkPrev;
    frame    = {shiftIn[30:0], pinF.mosi};
    spiWrite = sclkRise && bitCount == hmi_pkg::SPI_FRAME_LAST &&
               frame[31:24] == hmi_pkg::SPI_WRITE_OP;
    next_bitCount  = bitCount;
    next_shiftIn   = shiftIn;
    next_misoShift = misoShift;
    if (!spiSel)
      next_bitCount = 5'h00;
    else if (sclkRise)
    begin
      next_bitCount = bitCount + 5'h01;
      next_shiftIn  = frame;
    end
    if (sclkFall)
    begin
      if (bitCount == hmi_pkg::SPI_HDR_LAST)
        next_misoShift = (shiftIn[23:16] == hmi_pkg::SPI_READ_OP) ? readByte : 8'h00;
      else
        next_misoShift = {misoShift[6:0], 1'b0};
    end
    accWrite = parWrite || spiWrite;
    // one address per access, from the active path
    if (pinF.strap)
    begin
      accAddr = spiWrite ? frame[22:8] : shiftIn[14:0];
      accData = frame[7:0];
    end
    else
    begin
      accAddr = pinF.addr;
      accData = pinF.data;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPrev    <= 1'b1;
      sclkPrev  <= 1'b1;
      bitCount  <= 5'h00;
      shiftIn   <= 32'h0000_0000;
      misoShift <= 8'h00;
    end
    else
    begin
      wrPrev    <= pinF.wrN;
      sclkPrev  <= pinF.sclk;
      bitCount  <= next_bitCount;
      shiftIn   <= next_shiftIn;
      misoShift <= next_misoShift;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Socket interrupt flags and masks
  logic [3:0][3:0] sockFlags;
  logic [3:0][3:0] next_sockFlags;
  logic [3:0][3:0] sockMask;
  logic [3:0][3:0] next_sockMask;
  logic [3:0]      globMask;
  logic [3:0]      next_globMask;
  logic [3:0]      globFlags;
  logic            irqPending;
  logic            isGlobFlag;
  logic            isGlobMask;
  logic            isSockReg;

  assign isSockReg  = accAddr >= hmi_pkg::SOCK_BASE && accAddr < hmi_pkg::SOCK_END;
  assign isGlobFlag = accAddr == hmi_pkg::GIRQ_FLAG_OFS;
  assign isGlobMask = accAddr == hmi_pkg::GIRQ_MASK_OFS;

  generate
    for (gi = 0; gi < hmi_pkg::SOCKETS; gi++)
    begin : g_sock
      always_comb
      begin
        next_sockFlags[gi] = sockFlags[gi];
        next_sockMask[gi]  = sockMask[gi];
        if (accWrite && isSockReg && accAddr[9:8] == 2'(gi))
        begin
          // write one to clear a socket flag
          if (accAddr[7:0] == hmi_pkg::SIRQ_FLAG_OFS)
            next_sockFlags[gi] = sockFlags[gi] & ~accData[3:0];
          if (accAddr[7:0] == hmi_pkg::SIRQ_MASK_OFS)
            next_sockMask[gi] = accData[3:0];
        end
        // global write of one clears that socket
        if (accWrite && isGlobFlag && accData[gi])
          next_sockFlags[gi] = 4'h0;
        // events set flags, set beats a clear
        next_sockFlags[gi] = next_sockFlags[gi] | socketEvent[gi];
      end
      // masked sources stay out of the summary
      assign globFlags[gi] = |(sockFlags[gi] & sockMask[gi]);
    end
  endgenerate

  always_comb
  begin
    next_globMask = globMask;
    if (accWrite && isGlobMask)
      next_globMask = accData[3:0];
    irqPending = |(globFlags & globMask);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sockFlags <= '0;
      sockMask  <= {hmi_pkg::SOCKETS{hmi_pkg::SOCK_MASK_RESET}};
      globMask  <= hmi_pkg::GLOB_MASK_RESET;
      irq_n     <= 1'b1;
    end
    else
    begin
      sockFlags <= next_sockFlags;
      sockMask  <= next_sockMask;
      globMask  <= next_globMask;
      irq_n     <= !irqPending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register and buffer storage
  logic [7:0] regMem [0:hmi_pkg::REG_DEPTH-1];
  // one shared buffer for both directions
  logic [7:0] bufMem [0:hmi_pkg::BUF_DEPTH-1];
  logic [7:0] next_readByte;
  logic       isCommon;
  logic       isBuf;

  assign isCommon = accAddr < hmi_pkg::COMMON_END;
  assign isBuf    = accAddr >= hmi_pkg::TX_BASE;

  // Buffer has no reset: contents are undefined until written
  always_ff @(posedge clock)
  begin
    if (accWrite && isBuf)
      bufMem[accAddr[13:0]] <= accData;
    if (accWrite && (isCommon || isSockReg))
      regMem[accAddr[10:0]] <= accData;
  end

  always_comb
  begin
    next_readByte = 8'h00;
    if (isGlobFlag)
      next_readByte = {4'h0, globFlags};
    else if (isGlobMask)
      next_readByte = {4'h0, globMask};
    else if (isSockReg && accAddr[7:0] == hmi_pkg::SIRQ_FLAG_OFS)
      next_readByte = {4'h0, sockFlags[accAddr[9:8]]};
    else if (isSockReg && accAddr[7:0] == hmi_pkg::SIRQ_MASK_OFS)
      next_readByte = {4'h0, sockMask[accAddr[9:8]]};
    else if (isCommon || isSockReg)
      next_readByte = regMem[accAddr[10:0]];
    else if (isBuf)
      next_readByte = bufMem[accAddr[13:0]];
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      readByte <= 8'h00;
    else
      readByte <= next_readByte;
  end

  // drive the bus only during a selected read
  assign hostDataOut   = readByte;
  assign hostDataOe    = parSel && !pinF.rdN;
  assign serialDataOut = misoShift[7];
  assign serialDataOe  = spiSel;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  par_store_a: assert property (@(posedge clock) disable iff (!reset_n)
    parWrite && isBuf |=> bufMem[$past(accAddr[13:0])] == $past(accData))
    else $error("buffer write lost");
  read_drive_a: assert property (@(posedge clock) disable iff (!reset_n)
    parSel && !pinF.rdN && $stable(pinF.addr) |-> hostDataOe ##1
    (!hostDataOe || hostDataOut == $past(next_readByte)))
    else $error("read data not driven");
  bus_float_a: assert property (@(posedge clock) disable iff (!reset_n)
    pinF.csN |-> !hostDataOe && !parWrite)
    else $error("bus active without select");
  irq_set_a: assert property (@(posedge clock) disable iff (!reset_n)
    irqPending |=> !irq_n)
    else $error("interrupt not raised");
  irq_mask_a: assert property (@(posedge clock) disable iff (!reset_n)
    !irqPending |=> irq_n)
    else $error("masked interrupt asserted");
  sock_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    accWrite && isGlobFlag && accData[0] && socketEvent[0] == 4'h0 |=> sockFlags[0] == 4'h0)
    else $error("socket flags not cleared");
  event_wins_a: assert property (@(posedge clock) disable iff (!reset_n)
    socketEvent[1].receive |=> sockFlags[1][2])
    else $error("event lost");
  strap_route_a: assert property (@(posedge clock) disable iff (!reset_n)
    !pinF.strap |-> !serialDataOe && !spiWrite)
    else $error("serial active with strap low");
  spi_select_a: assert property (@(posedge clock) disable iff (!reset_n)
    pinF.ssN |-> !serialDataOe ##1 bitCount == 5'h00)
    else $error("serial active without select");
  gap_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
    !isCommon && !isSockReg && !isBuf && !isGlobFlag && !isGlobMask |=> readByte == 8'h00)
    else $error("reserved space not zero");

  par_write_c: cover property (@(posedge clock) disable iff (!reset_n) parWrite && isBuf);
  par_read_c: cover property (@(posedge clock) disable iff (!reset_n) hostDataOe ##1 !hostDataOe);
  spi_write_c: cover property (@(posedge clock) disable iff (!reset_n) spiWrite);
  irq_cycle_c: cover property (@(posedge clock) disable iff (!reset_n) !irq_n ##[1:50] irq_n);

endmodule

// ### hmi_mcu_model.sv
// Microcontroller model: parallel bus master and serial master
`timescale 1ns/100ps
module hmi_mcu_model
(
  input  wire logic        clock,
  input  wire logic [7:0]  bus,
  input  wire logic        busOe,
  input  wire logic        miso,
  output      logic [14:0] addr,
  output      logic [7:0]  dout,
  output      logic        doe,
  output      logic        csN,
  output      logic        wrN,
  output      logic        rdN,
  output      logic        sclk,
  output      logic        ssN,
  output      logic        mosi
);
  initial
  begin
    {addr, dout, doe, sclk, mosi} = '0;
    {csN, wrN, rdN, ssN} = 4'hf;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////
  // host drives write
  task automatic pwr(input logic [14:0] a, input logic [7:0] d, input logic sel);
    @(posedge clock);
    addr <= a;
    dout <= d;
    doe <= 1'b1;
    csN <= ~sel;
    wrN <= 1'b0;
    tick(6);
    wrN <= 1'b1;
    // Filter delay: hold address and data past the stored edge
    tick(6);
    addr <= 15'h0000;
    doe <= 1'b0;
    csN <= 1'b1;
    tick(6);
  endtask

  task automatic prd(input logic [14:0] a, input logic sel, output logic [7:0] d, output logic o);
    @(posedge clock);
    addr <= a;
    csN <= ~sel;
    rdN <= 1'b0;
    tick(8);
    d = bus;
    o = busOe;
    rdN <= 1'b1;
    csN <= 1'b1;
    addr <= 15'h0000;
    tick(6);
  endtask
  ////////////////////////////////////////////////////////////
  // mode 0 or 3 frame
  task automatic sfr(input logic [31:0] f, input logic sel, input logic m3, output logic [7:0] r);
    @(posedge clock);
    // Idle level settles before select, else mode 3 sees a false first edge
    sclk <= m3;
    tick(4);
    ssN <= ~sel;
    tick(8);
    for (int i = 31; i >= 0; i--)
    begin
      sclk <= 1'b0;
      mosi <= f[i];
      tick(4);
      sclk <= 1'b1;
      tick(4);
      // Late sample, the slave output lags its clock edge
      if (i < 8)
        r[i] = miso;
    end
    sclk <= m3;
    tick(4);
    ssN <= 1'b1;
    mosi <= 1'b0;
    tick(8);
  endtask
endmodule

// ### tb_host_mcu_interface.sv
// Testbench of the host access port
`timescale 1ns/100ps
module tb_host_mcu_interface;
  logic                        clock   = 1'b0;
  logic                        reset_n = 1'b0;
  logic                        strap   = 1'b0;
  logic                        fp      = 1'b0;
  hmi_pkg::hmi_sock_ev_t [3:0] ev      = '0;
  logic [14:0]                 addr;
  logic [7:0]                  dout;
  logic [7:0]                  bus;
  logic [7:0]                  hd;
  logic                        hoe, doe, csN, wrN, rdN, sclk, ssN, mosi, miso, so, soe, irq_n;
  int                          nFail   = 0;
  int                          checks  = 0;

  always #50 clock = ~clock;
  // Undriven lines show a changing pattern, never a stale value
  always @(posedge clock) fp <= ~fp;
  assign bus  = hoe ? hd : doe ? dout : {8{fp}};
  assign miso = soe ? so : fp;

  hmi_host_port u_hmi_host_port
  (
    .clock           (clock),
    .reset_n         (reset_n),
    .hostAddressBus  (addr),
    .hostDataIn      (bus),
    .hostDataOut     (hd),
    .hostDataOe      (hoe),
    .chipSelect_n    (csN),
    .writeStrobe_n   (wrN),
    .readStrobe_n    (rdN),
    .irq_n           (irq_n),
    .serialModeStrap (strap),
    .serialClock     (sclk),
    .serialSelect_n  (ssN),
    .serialDataIn    (mosi),
    .serialDataOut   (so),
    .serialDataOe    (soe),
    .socketEvent     (ev)
  );

  hmi_mcu_model u_hmi_mcu_model
  (
    .clock (clock),
    .bus   (bus),
    .busOe (hoe),
    .miso  (miso),
    .addr  (addr),
    .dout  (dout),
    .doe   (doe),
    .csN   (csN),
    .wrN   (wrN),
    .rdN   (rdN),
    .sclk  (sclk),
    .ssN   (ssN),
    .mosi  (mosi)
  );
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      nFail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    u_hmi_mcu_model.pwr(a, d, 1'b1);
  endtask

  task automatic rdc(input logic [14:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       o;
    u_hmi_mcu_model.prd(a, 1'b1, d, o);
    chk({7'h00, o}, 8'h01);
    chk(d, e);
  endtask

  task automatic pulse(input int s, input logic [3:0] e);
    @(posedge clock);
    ev[s] <= e;
    @(posedge clock);
    ev <= '0;
    repeat (3) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({7'h00, irq_n}, 8'h01);
    chk({6'h00, hoe, soe}, 8'h00);
    rdc(15'h0016, 8'h0f);
    rdc(15'h072c, 8'h0f);
  endtask

  task automatic t_map;
    logic [14:0] a [7] = '{15'h002f, 15'h0400, 15'h07ff, 15'h4000, 15'h5fff, 15'h6000, 15'h7fff};
    logic [14:0] z [4] = '{15'h0030, 15'h03ff, 15'h0800, 15'h3fff};
    for (int i = 0; i < 7; i++)
      wr(a[i], 8'(8'ha5 ^ i));
    for (int i = 0; i < 7; i++)
      rdc(a[i], 8'(8'ha5 ^ i));
    for (int i = 0; i < 4; i++)
    begin
      wr(z[i], 8'h77);
      rdc(z[i], 8'h00);
    end
  endtask

  task automatic t_nocs;
    logic [7:0] d;
    logic       o;
    wr(15'h4010, 8'h11);
    u_hmi_mcu_model.pwr(15'h4010, 8'h22, 1'b0);
    u_hmi_mcu_model.prd(15'h4010, 1'b0, d, o);
    chk({7'h00, o}, 8'h00);
    rdc(15'h4010, 8'h11);
  endtask

  task automatic t_irq;
    for (int s = 0; s < 4; s++)
      for (int e = 0; e < 4; e++)
      begin
        pulse(s, 4'(1 << e));
        chk({7'h00, irq_n}, 8'h00);
        rdc(15'h0402 + 15'(s << 8), 8'(1 << e));
        rdc(15'h0015, 8'(1 << s));
        wr(15'h0402 + 15'(s << 8), 8'(1 << e));
        chk({7'h00, irq_n}, 8'h01);
      end
    wr(15'h052c, 8'h0b);
    pulse(1, 4'h4);
    chk({7'h00, irq_n}, 8'h01);
    pulse(1, 4'h1);
    chk({7'h00, irq_n}, 8'h00);
    wr(15'h0015, 8'h02);
    chk({7'h00, irq_n}, 8'h01);
    rdc(15'h0502, 8'h00);
    wr(15'h052c, 8'h0f);
    wr(15'h0016, 8'h0e);
    pulse(0, 4'h8);
    chk({7'h00, irq_n}, 8'h01);
    wr(15'h0016, 8'h0f);
    chk({7'h00, irq_n}, 8'h00);
    wr(15'h0402, 8'h08);
    chk({7'h00, irq_n}, 8'h01);
  endtask

  task automatic t_serial;
    logic [7:0] r;
    logic       o;
    @(posedge clock);
    strap <= 1'b1;
    repeat (6) @(posedge clock);
    u_hmi_mcu_model.pwr(15'h4010, 8'h33, 1'b1);
    u_hmi_mcu_model.prd(15'h4010, 1'b1, r, o);
    chk({7'h00, o}, 8'h00);
    u_hmi_mcu_model.sfr({8'h0f, 16'h4010, 8'h00}, 1'b1, 1'b0, r);
    chk(r, 8'h11);
    u_hmi_mcu_model.sfr({8'hf0, 16'h4021, 8'hc3}, 1'b1, 1'b0, r);
    u_hmi_mcu_model.sfr({8'h0f, 16'h4021, 8'h00}, 1'b1, 1'b1, r);
    chk(r, 8'hc3);
    u_hmi_mcu_model.sfr({8'hf0, 16'h4021, 8'h5a}, 1'b0, 1'b0, r);
    u_hmi_mcu_model.sfr({8'h0f, 16'h4021, 8'h00}, 1'b1, 1'b1, r);
    chk(r, 8'hc3);
    @(posedge clock);
    strap <= 1'b0;
    repeat (6) @(posedge clock);
    u_hmi_mcu_model.sfr({8'hf0, 16'h4021, 8'h99}, 1'b1, 1'b0, r);
    rdc(15'h4021, 8'hc3);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d failures %0d", checks, nFail);
    if (nFail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (hmi_pkg::RESET_MIN_CYC) @(posedge clock);
    reset_n <= 1'b1;
    repeat (6) @(posedge clock);
    t_reset;
    t_map;
    t_nocs;
    t_irq;
    t_serial;
    conclude;
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    nFail++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude;
  end
endmodule
